/* File: hdl/twlwp_pkg.sv */
// Purpose: constants for the three-wire latch write port
// Assumes: serial pins sampled by the 250 MHz system clock
// Notes: word is 24 bits, MSB first, select bits in bits 1:0
//
// Summary of operation
// - Each rising edge of the serial clock shifts one data bit into the input register.
// - A rising load strobe moves the 24 held bits into the latch that the select bits name.
// - The port is write only and offers no readback of latch contents.
// - The chip-enable input low forces the device into power-down.
// - In lock-detect mode, outside power-down, the status pin shows the lock state as a steady level.
// - Select bits 0,0 write the control latch.
// - Select bits 0,1 write the reference counter latch.
// - In power-down the input register still shifts and latches words.
package twlwp_pkg;
	localparam int        WORD_W        = 24;
	localparam int        SEL_LO_POS    = 0;
	localparam int        SEL_HI_POS    = 1;
	localparam logic [1:0] SEL_CONTROL  = 2'h0;
	localparam logic [1:0] SEL_REFCNT   = 2'h1;
	localparam logic [1:0] SEL_FBDIV    = 2'h2;
	localparam int        NUM_LATCH     = 3;
	localparam int        CTL_IDX       = 0;
	localparam int        REF_IDX       = 1;
	localparam int        FB_IDX        = 2;
	localparam logic [23:0] LATCH_RST   = 24'h000000;
	localparam int        MUX_POS       = 5;
	localparam logic [2:0] MUX_LOCK     = 3'h1;
	localparam logic [2:0] MUX_LOW      = 3'h0;
	localparam int        PD1_POS       = 20;
	localparam int        PD2_POS       = 21;
endpackage : twlwp_pkg

/* File: hdl/twlwp_port.sv */
// Purpose: three-wire write-only serial port with latch decode
// Assumes: serial pins are asynchronous to clk and sampled by it
// Notes: status pin shows lock gated by power-down, or a forced low
`timescale 1ns/1ps
`default_nettype none
module twlwp_port
	import twlwp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        serial_clk,
	input  wire logic        serial_data,
	input  wire logic        load_strobe,
	input  wire logic        chip_enable,
	input  wire logic        pll_locked,
	output logic             status_monitor_pin,
	output logic             power_down,
	output logic [23:0]      control_latch,
	output logic [23:0]      refcnt_latch,
	output logic [23:0]      fbdiv_latch,
	output logic             latch_update
);

	////////////////////////////////////////////////////////////////
	// Input synchronisers, two stages each, plus edge history
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [3:0] sync_next;
	logic [1:0] hist_reg;
	logic [1:0] hist_next;
	logic       sclk_s;
	logic       sdat_s;
	logic       le_s;
	logic       ce_s;

	always_comb
	begin
		sync_next = {chip_enable, load_strobe, serial_data, serial_clk};
		hist_next = {sync2_reg[2], sync2_reg[0]};
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			hist_reg  <= 2'h0;
		end
		else
		begin
			sync1_reg <= sync_next;
			sync2_reg <= sync1_reg;
			hist_reg  <= hist_next;
		end
	end

	assign sclk_s = sync2_reg[0];
	assign sdat_s = sync2_reg[1];
	assign le_s   = sync2_reg[2];
	assign ce_s   = sync2_reg[3];

	////////////////////////////////////////////////////////////////
	// Edge detection on the synchronised pins
	logic sclk_rise;
	logic le_rise;

	// Serial clock rising edge
	assign sclk_rise = sclk_s && !hist_reg[0];
	// Load strobe rising edge
	assign le_rise   = le_s && !hist_reg[1];

	////////////////////////////////////////////////////////////////
	// Input shift register
	logic [WORD_W-1:0] shift_reg;
	logic [WORD_W-1:0] shift_next;

	always_comb
	begin
		shift_next = shift_reg;
		if (sclk_rise)
		begin
			shift_next = {shift_reg[WORD_W-2:0], sdat_s};
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shift_reg <= LATCH_RST;
		end
		else
		begin
			shift_reg <= shift_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Commit decode on strobe rise
	logic [1:0]           sel;
	logic [NUM_LATCH-1:0] wr_en;
	logic                 upd_reg;
	logic                 upd_next;

	always_comb
	begin
		sel      = {shift_reg[SEL_HI_POS], shift_reg[SEL_LO_POS]};
		wr_en    = '0;
		upd_next = 1'b0;
		if (le_rise)
		begin
			upd_next = 1'b1;
			wr_en[CTL_IDX] = (sel == SEL_CONTROL);
			wr_en[REF_IDX] = (sel == SEL_REFCNT);
			wr_en[FB_IDX]  = (sel == SEL_FBDIV);
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			upd_reg <= 1'b0;
		end
		else
		begin
			upd_reg <= upd_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Configuration latches, one per select code 0 to 2; code 3 writes none
	wire logic [WORD_W-1:0] latch_q [NUM_LATCH];

	for (genvar gi = 0; gi < NUM_LATCH; gi++)
	begin : g_latch
		logic [WORD_W-1:0] latch_reg;
		logic [WORD_W-1:0] latch_next;

		always_comb
		begin
			latch_next = latch_reg;
			if (wr_en[gi])
			begin
				latch_next = shift_reg;
			end
		end

		always_ff @(posedge clk or negedge rst_b)
		begin
			if (!rst_b)
			begin
				latch_reg <= LATCH_RST;
			end
			else
			begin
				latch_reg <= latch_next;
			end
		end

		assign latch_q[gi] = latch_reg;
	end

	logic [WORD_W-1:0] ctl_reg;

	assign ctl_reg = latch_q[CTL_IDX];

	////////////////////////////////////////////////////////////////
	// Power-down and status pin
	logic pd_reg;
	logic pd_next;
	logic mon_reg;
	logic mon_next;

	always_comb
	begin
		// Chip enable low or programmed power-down
		pd_next = !ce_s || ctl_reg[PD1_POS];
		// Lock level on the status pin
		case (ctl_reg[MUX_POS+2:MUX_POS])
			MUX_LOCK: mon_next = pll_locked && !pd_reg;
			MUX_LOW:  mon_next = 1'b0;
			default:  mon_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pd_reg  <= 1'b1;
			mon_reg <= 1'b0;
		end
		else
		begin
			pd_reg  <= pd_next;
			mon_reg <= mon_next;
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs, each straight from a flip-flop
	assign status_monitor_pin = mon_reg;
	assign power_down         = pd_reg;
	assign control_latch      = latch_q[CTL_IDX];
	assign refcnt_latch       = latch_q[REF_IDX];
	assign fbdiv_latch        = latch_q[FB_IDX];
	assign latch_update       = upd_reg;

endmodule : twlwp_port
`default_nettype wire

/* File: bench/twlwp_sva.sv */
// Purpose: port checker. Assumes: pins sampled by clk. Notes: bound in the test top
`timescale 1ns/1ps
`default_nettype none
module twlwp_sva
	import twlwp_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        load_strobe,
	input wire logic        chip_enable,
	input wire logic        status_monitor_pin,
	input wire logic        power_down,
	input wire logic        latch_update,
	input wire logic [23:0] control_latch,
	input wire logic [23:0] refcnt_latch,
	input wire logic [23:0] fbdiv_latch
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_u; $rose(load_strobe) |-> ##[2:4] latch_update; endproperty
	a_u: assert property (p_u) else $error("no update");
	property p_o; latch_update |=> !latch_update; endproperty
	a_o: assert property (p_o) else $error("long update");
	property p_c; $changed(control_latch) |-> latch_update; endproperty
	a_c: assert property (p_c) else $error("control");
	property p_r; $changed(refcnt_latch) |-> latch_update; endproperty
	a_r: assert property (p_r) else $error("refcnt");
	property p_f; $changed(fbdiv_latch) |-> latch_update; endproperty
	a_f: assert property (p_f) else $error("fbdiv");
	property p_e; !chip_enable [*4] |-> power_down; endproperty
	a_e: assert property (p_e) else $error("enable");
	property p_s; power_down [*2] |-> !status_monitor_pin; endproperty
	a_s: assert property (p_s) else $error("status");
	property p_x;
		$rose(status_monitor_pin) |-> control_latch[MUX_POS+2:MUX_POS] == MUX_LOCK;
	endproperty
	a_x: assert property (p_x) else $error("mode");
	c_u: cover property (latch_update);
	c_d: cover property (power_down && latch_update);
	c_s: cover property ($rose(status_monitor_pin));
endmodule : twlwp_sva
`default_nettype wire

/* File: bench/twlwp_host.sv */
// Purpose: host master model. Assumes: 64 ns serial clock. Notes: idle data inverted
`timescale 1ns/1ps
`default_nettype none
module twlwp_host
(
	input  wire logic clk,
	output var logic  serial_clk,
	output var logic  serial_data,
	output var logic  load_strobe
);
	// Half period of 8 clk, 64 ns serial clock
	localparam int HALF = 8;
	initial
	begin
		serial_clk  = 1'b0;
		serial_data = 1'b0;
		load_strobe = 1'b0;
	end
	task automatic send(input logic [23:0] w);
		load_strobe <= 1'b0;
		for (int i = 47; i >= 0; i--)
		begin
			if (i[0])
			begin
				serial_data <= w[i/2];
			end
			repeat (HALF) @(posedge clk);
			serial_clk <= i[0];
		end
		serial_data <= ~serial_data;
		load_strobe <= 1'b1;
		repeat (HALF) @(posedge clk);
	endtask : send
endmodule : twlwp_host
`default_nettype wire

/* File: bench/three_wire_latch_write_port_test.sv */
// Purpose: port test. Assumes: host model drives pins. Notes: one task a scenario
`timescale 1ns/1ps
`default_nettype none
module three_wire_latch_write_port_test;
	logic clk = 1'b0, rst_b = 1'b0, chip_enable = 1'b1, pll_locked = 1'b1;
	logic serial_clk, serial_data, load_strobe, status_monitor_pin, power_down, latch_update;
	logic [23:0] control_latch, refcnt_latch, fbdiv_latch;
	int miscompares = 0, checked = 0, updates = 0;
	always #2 clk = ~clk;
	always @(negedge clk)
	begin
		if (latch_update === 1'b1)
		begin
			updates++;
		end
	end
	twlwp_host host (.*);
	twlwp_port dut (.*);
	task automatic chk(input string n, input logic [23:0] e, s);
		checked++;
		if (s !== e) $display("unexpected %s %h %h", n, e, s);
		miscompares += int'(s !== e);
	endtask : chk
	task automatic results(input int late);
		miscompares += late;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task automatic t_sel();
		host.send(24'hA50C20);
		host.send(24'h3C5A61);
		host.send(24'h5AC3A6);
		host.send(24'hFFFFFF);
		chk("ctl", 24'hA50C20, control_latch);
		chk("ref", 24'h3C5A61, refcnt_latch);
		chk("fb", 24'h5AC3A6, fbdiv_latch);
		chk("st", 24'h1, {23'h0, status_monitor_pin});
		chk("upd", 24'h4, 24'(updates));
		$display("t_sel done");
	endtask : t_sel
	task automatic t_lock();
		pll_locked <= 1'b0;
		repeat (4) @(posedge clk);
		chk("st_unlock", 24'h0, {23'h0, status_monitor_pin});
		pll_locked <= 1'b1;
		repeat (4) @(posedge clk);
		chk("st_lock", 24'h1, {23'h0, status_monitor_pin});
		$display("t_lock done");
	endtask : t_lock
	task automatic t_pd();
		chip_enable <= 1'b0;
		repeat (6) @(posedge clk);
		chk("pd", 24'h1, {23'h0, power_down});
		chk("st_pd", 24'h0, {23'h0, status_monitor_pin});
		host.send(24'h1F0F01);
		chk("ref", 24'h1F0F01, refcnt_latch);
		chk("upd", 24'h5, 24'(updates));
		$display("t_pd done");
	endtask : t_pd
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		t_sel();
		t_lock();
		t_pd();
		results(0);
	end
	initial #40000 results(1);
endmodule : three_wire_latch_write_port_test
bind twlwp_port twlwp_sva chk_sva (.*);
`default_nettype wire
